// ==== common/tdc_pkg.sv ====
/*
  Shared constants and types for the multihit TDC event digitizer.
  Assumes a 100 MHz APB clock; all timing counts derive from it.
*/
package tdc_pkg;
  // ==========================================================
  // Geometry
  localparam int NCH = 32;
  localparam int NHIT = 16;
  localparam int NGRP = 8;
  localparam int GRP_W = 4;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_HITS = 8'h04;
  localparam logic [7:0] A_IDB = 8'h08;
  localparam logic [7:0] A_WIN = 8'h0c;
  localparam logic [7:0] A_FSC = 8'h10;
  localparam logic [7:0] A_TRIG = 8'h14;
  localparam logic [7:0] A_TEST = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1c;
  localparam logic [7:0] A_DATA = 8'h20;
  localparam int TEST_GO_BIT = 31;
  localparam int TRIG_LATCH_BIT = 16;
  localparam int WIN_LSB_POS = 16;
  // ==========================================================
  // Reset values
  localparam logic [3:0] HITS_RST = 4'hf;
  localparam logic [11:0] FSC_RST = 12'hfa0;
  // ==========================================================
  // Timing
  localparam int CLK_PS = 10000;
  localparam int BIN_PS = 500;
  localparam logic [15:0] BINS_PER_CLK = 16'(CLK_PS / BIN_PS);
  localparam int FS_STEP_PS = 8000;
  localparam int FS_SHIFT = $clog2(FS_STEP_PS / BIN_PS);
  localparam int CLK_NS = 10;
  localparam int DEAD_BASE_NS = 1800;
  localparam int DEAD_HIT_NS = 100;
  localparam int DEAD_HIT2_NS = 200;
  localparam int ECL_WORD_NS = 100;
  localparam int DEAD_BASE_CYC = (DEAD_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEAD_HIT_CYC = (DEAD_HIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEAD_HIT2_CYC = (DEAD_HIT2_NS + CLK_NS - 1) / CLK_NS;
  localparam int ECL_CYC = (ECL_WORD_NS + CLK_NS - 1) / CLK_NS;
  localparam int EV_WORST = 1 + NCH * NHIT * 2;
  // ==========================================================
  // Types
  typedef struct packed {
    logic acq_en;
    logic suppress_empty;
    logic both_edges;
    logic double_word;
    logic common_start;
  } ctrl_t;
  typedef struct packed {
    logic rise;
    logic [15:0] stamp;
  } hit_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_ACQ = 4'b0010,
    S_UNLOAD = 4'b0100,
    S_DEAD = 4'b1000
  } state_t;
endpackage

// ==== verilog/multihit_tdc_event_digitizer.sv ====
/*
  32-channel multihit TDC: edge capture, event formatting, event
  buffer, APB registers, ECL event port and grouped trigger outputs.
  Assumes pins are asynchronous to pclk; timing is coarse (one clock).
*/
`timescale 1ns/1ns
`default_nettype none
module multihit_tdc_event_digitizer
  import tdc_pkg::*;
#(
  parameter int EV_DEPTH = 4096,
  parameter int EV_MAX = 31
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] hit_in,
  input wire logic common_hit_input,
  input wire logic timeout_input,
  input wire logic fast_clear_input,
  input wire logic readout_enable_input,
  output logic [NGRP-1:0] trigger_out,
  output logic cannot_accept_hits_output,
  output logic [15:0] ecl_data,
  output logic ecl_write_strobe,
  output logic ecl_pass,
  output logic addressed_led
);
  localparam int AW = $clog2(EV_DEPTH);
  localparam int NS = NCH + 4;

  // ==========================================================
  // Pin synchronisers
  logic [NS-1:0] sy1, sy2, sy3;
  logic [NCH-1:0] hits, hits_d, rise, fall, acc;
  logic com_rise, to_rise, clr_rise, ren;
  logic test_lvl, test_com;

  // Two stages before use; third stage only for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1 <= '0;
      sy2 <= '0;
      sy3 <= '0;
      hits_d <= '0;
    end else begin
      sy1 <= {readout_enable_input, fast_clear_input, timeout_input, common_hit_input, hit_in};
      sy2 <= sy1;
      sy3 <= sy2;
      hits_d <= hits;
    end
  end

  assign hits = sy2[NCH-1:0] | {NCH{test_lvl}};
  // Edge per clock: 10 ns pair resolution, bounded by the sample rate
  assign rise = hits & ~hits_d;
  assign fall = ~hits & hits_d;
  assign com_rise = sy2[NCH] & ~sy3[NCH];
  assign to_rise = sy2[NCH+1] & ~sy3[NCH+1];
  assign clr_rise = sy2[NCH+2] & ~sy3[NCH+2];
  assign ren = sy2[NCH+3];

  // ==========================================================
  // Registers
  ctrl_t ctrl;
  logic [3:0] hits_m1;
  logic [7:0] idb, tdel, twid, tcount, tdur;
  logic [15:0] offs;
  logic [1:0] lsb;
  logic [11:0] fsc;
  logic tlatch, test_go;
  logic wr_acc, rd_acc;
  state_t st;
  logic [4:0] ev_count;
  logic [AW:0] wr_ptr, cm_ptr, rd_ptr;
  logic ecl_act, full;
  hit_t hmem [NCH][NHIT];
  logic [4:0] cnt [NCH];
  logic [15:0] ev_mem [EV_DEPTH];
  logic ev_end [EV_DEPTH];

  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_acc = psel & penable & pready & ~pwrite;

  // Register writes; a test start is honoured only in common start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
      hits_m1 <= HITS_RST;
      idb <= '0;
      offs <= '0;
      lsb <= '0;
      fsc <= FSC_RST;
      tdel <= '0;
      twid <= '0;
      tlatch <= 1'b0;
      tcount <= '0;
      tdur <= '0;
      test_go <= 1'b0;
    end else begin
      test_go <= 1'b0;
      if (wr_acc) begin
        unique case (paddr)
          A_CTRL: ctrl <= pwdata[4:0];
          A_HITS: hits_m1 <= pwdata[3:0];
          A_IDB: idb <= pwdata[7:0];
          A_WIN: begin
            offs <= pwdata[15:0];
            lsb <= pwdata[WIN_LSB_POS+1:WIN_LSB_POS];
          end
          A_FSC: fsc <= pwdata[11:0];
          A_TRIG: begin
            tdel <= pwdata[7:0];
            twid <= pwdata[15:8];
            tlatch <= pwdata[TRIG_LATCH_BIT];
          end
          A_TEST: begin
            tcount <= pwdata[7:0];
            tdur <= pwdata[15:8];
            test_go <= pwdata[TEST_GO_BIT] & ctrl.common_start;
          end
          default: ;
        endcase
      end
    end
  end

  // Read data is captured in the setup cycle, so pready is high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      addressed_led <= 1'b0;
    end else begin
      addressed_led <= psel;
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        prdata <= '0;
        unique case (paddr)
          A_CTRL: prdata <= {27'h0, ctrl};
          A_HITS: prdata <= {28'h0, hits_m1};
          A_IDB: prdata <= {24'h0, idb};
          A_WIN: prdata <= {14'h0, lsb, offs};
          A_FSC: prdata <= {20'h0, fsc};
          A_TRIG: prdata <= {15'h0, tlatch, twid, tdel};
          A_TEST: prdata <= {16'h0, tdur, tcount};
          A_STAT: prdata <= {18'h0, full, cannot_accept_hits_output, st, 3'h0, ev_count};
          A_DATA: prdata <= {(ev_count != 5'h0) & ~ecl_act, 14'h0, ev_end[rd_ptr[AW-1:0]],
                             ev_mem[rd_ptr[AW-1:0]]};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================
  // Test pulser: one common, then count pulses of dur+1 cycles high, dur+1 low
  logic [7:0] t_left, t_tmr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_com <= 1'b0;
      test_lvl <= 1'b0;
      t_left <= '0;
      t_tmr <= '0;
    end else begin
      test_com <= test_go;
      if (test_go) begin
        t_left <= tcount;
        t_tmr <= tdur;
        test_lvl <= 1'b0;
      end else if (t_left != 8'h0) begin
        if (t_tmr == 8'h0) begin
          t_tmr <= tdur;
          test_lvl <= ~test_lvl;
          if (test_lvl) begin
            t_left <= t_left - 8'h1;
          end
        end else begin
          t_tmr <= t_tmr - 8'h1;
        end
      end
    end
  end

  // ==========================================================
  // Capture front end
  logic [15:0] stamp, ref_stamp, fs_bins;
  logic [16:0] win;
  logic start_ev, any_hit, cnt_clr, restart;

  assign fs_bins = {fsc, FS_SHIFT'(0)};
  assign start_ev = com_rise | test_com;
  assign restart = (st == S_ACQ) & ~ctrl.common_start & (win >= {1'b0, fs_bins});
  assign cnt_clr = clr_rise | (st == S_IDLE) | restart;

  // Coarse counter in 500 ps bins, 20 bins per clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp <= '0;
    end else begin
      stamp <= stamp + BINS_PER_CLK;
    end
  end

  always_comb begin
    any_hit = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      acc[c] = (st == S_ACQ) && (rise[c] || (ctrl.both_edges && fall[c]))
               && (cnt[c] <= {1'b0, hits_m1});
      any_hit = any_hit | (cnt[c] != 5'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        cnt[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (cnt_clr) begin
          cnt[c] <= '0;
        end else if (acc[c]) begin
          cnt[c] <= cnt[c] + 5'h1;
        end
      end
    end
  end

  // Hit store has no reset; counts say which entries are live
  always_ff @(posedge pclk) begin
    for (int c = 0; c < NCH; c++) begin
      if (acc[c]) begin
        hmem[c][cnt[c][3:0]] <= '{rise: rise[c], stamp: stamp};
      end
    end
  end

  // ==========================================================
  // Event formatter
  logic [4:0] uch;
  logic [3:0] uidx;
  logic uhalf, hdr_done, hit_here, in_win, push_en, tag_we;
  logic [15:0] t, rel, q, push_word;
  logic [9:0] n_hits;
  logic [14:0] dead_cnt, dead_tgt;
  hit_t h;

  always_comb begin
    h = hmem[uch][uidx];
    t = ctrl.common_start ? h.stamp - ref_stamp : ref_stamp - h.stamp;
    rel = t - offs;
    q = rel >> lsb;
    in_win = (t < fs_bins) && (ctrl.double_word ||
             ((t >= offs) && (ctrl.both_edges ? q < 16'h0200 : q < 16'h0400)));
    hit_here = {1'b0, uidx} < cnt[uch];
    push_en = 1'b0;
    push_word = '0;
    if (st == S_UNLOAD) begin
      if (!hdr_done) begin
        push_en = !(ctrl.suppress_empty && !any_hit);
        push_word = {1'b1, ctrl.both_edges, ctrl.double_word, ctrl.common_start, 4'h0, idb};
      end else if (hit_here && in_win) begin
        push_en = 1'b1;
        if (ctrl.double_word) begin
          push_word = {1'b0, uch, h.rise, ~uhalf, uhalf ? t[7:0] : t[15:8]};
        end else if (ctrl.both_edges) begin
          push_word = {1'b0, uch, h.rise, q[8:0]};
        end else begin
          push_word = {1'b0, uch, q[9:0]};
        end
      end
    end
    tag_we = (st == S_UNLOAD) && hdr_done && !hit_here && (uch == 5'h1f) && (wr_ptr != cm_ptr);
  end

  assign dead_tgt = 15'(DEAD_BASE_CYC) + n_hits * (ctrl.double_word ? 15'(DEAD_HIT2_CYC)
                    : 15'(DEAD_HIT_CYC));

  // Acquisition sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= S_IDLE;
      ref_stamp <= '0;
      win <= '0;
      uch <= '0;
      uidx <= '0;
      uhalf <= 1'b0;
      hdr_done <= 1'b0;
      n_hits <= '0;
      dead_cnt <= '0;
      wr_ptr <= '0;
      cm_ptr <= '0;
    end else if (clr_rise) begin
      st <= S_IDLE;
      wr_ptr <= cm_ptr;
    end else begin
      if (push_en) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      unique case (st)
        S_IDLE: begin
          win <= '0;
          if (ctrl.acq_en && !full) begin
            if (!ctrl.common_start) begin
              st <= S_ACQ;
            end else if (start_ev) begin
              st <= S_ACQ;
              ref_stamp <= stamp;
            end
          end
        end
        S_ACQ: begin
          if (ctrl.common_start) begin
            win <= win + {1'b0, BINS_PER_CLK};
            if (start_ev) begin
              st <= S_IDLE; // Extra common before timeout kills the event
            end else if (to_rise || win >= {1'b0, fs_bins}) begin
              st <= S_UNLOAD;
            end
          end else if (com_rise) begin
            st <= S_UNLOAD;
            ref_stamp <= stamp;
          end else if (restart || !any_hit) begin
            win <= '0; // Stale hits beyond full scale are dropped
          end else begin
            win <= win + {1'b0, BINS_PER_CLK};
          end
          uch <= '0;
          uidx <= '0;
          uhalf <= 1'b0;
          hdr_done <= 1'b0;
          n_hits <= '0;
          dead_cnt <= '0;
        end
        S_UNLOAD: begin
          dead_cnt <= dead_cnt + 15'h1;
          if (!hdr_done) begin
            hdr_done <= 1'b1;
          end else if (hit_here) begin
            if (ctrl.double_word && in_win && !uhalf) begin
              uhalf <= 1'b1;
            end else begin
              uhalf <= 1'b0;
              uidx <= uidx + 4'h1;
              n_hits <= n_hits + 10'h1;
            end
          end else begin
            uidx <= '0;
            if (uch == 5'h1f) begin
              st <= S_DEAD;
              cm_ptr <= wr_ptr;
            end else begin
              uch <= uch + 5'h1;
            end
          end
        end
        S_DEAD: begin
          dead_cnt <= dead_cnt + 15'h1;
          if (dead_cnt >= dead_tgt) begin
            st <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Event memory; end tag marks the last word of a committed event
  always_ff @(posedge pclk) begin
    if (push_en) begin
      ev_mem[wr_ptr[AW-1:0]] <= push_word;
      ev_end[wr_ptr[AW-1:0]] <= 1'b0;
    end
    if (tag_we) begin
      ev_end[AW'(wr_ptr - 1'b1)] <= 1'b1;
    end
  end

  // ==========================================================
  // Readout: APB data pops and ECL event stream
  logic pop, pop_apb, ecl_pop, armed;
  logic [3:0] ecl_tmr;

  // Full also when a worst-case event would not fit
  assign full = (ev_count >= 5'(EV_MAX)) || ((wr_ptr - rd_ptr) > (AW+1)'(EV_DEPTH - EV_WORST));
  assign pop_apb = rd_acc && (paddr == A_DATA) && (ev_count != 5'h0) && !ecl_act;
  assign ecl_pop = ecl_act && ren && (ecl_tmr == 4'h0);
  assign pop = pop_apb | ecl_pop;

  // Committed event count; commit is the tag write of the last word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_count <= '0;
      rd_ptr <= '0;
    end else begin
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      ev_count <= ev_count + {4'h0, tag_we & ~clr_rise}
                  - {4'h0, pop & ev_end[rd_ptr[AW-1:0]]};
    end
  end

  // One event per enable cycle; enable must drop before the next event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
      ecl_act <= 1'b0;
      ecl_tmr <= '0;
      ecl_data <= '0;
      ecl_write_strobe <= 1'b0;
      ecl_pass <= 1'b0;
    end else begin
      ecl_write_strobe <= 1'b0;
      if (!ren) begin
        armed <= 1'b1;
        ecl_act <= 1'b0;
        ecl_pass <= 1'b0;
      // A DATA read in flight already saw valid, so the stream must not start under it
      end else if (armed && !ecl_act && ev_count != 5'h0 && !(psel && !pwrite && paddr == A_DATA)) begin
        ecl_act <= 1'b1;
        ecl_tmr <= '0;
      end else if (ecl_pop) begin
        ecl_data <= ev_mem[rd_ptr[AW-1:0]];
        ecl_write_strobe <= 1'b1;
        ecl_tmr <= 4'(ECL_CYC - 1);
        if (ev_end[rd_ptr[AW-1:0]]) begin
          ecl_act <= 1'b0;
          armed <= 1'b0;
          ecl_pass <= 1'b1;
        end
      end else if (ecl_act) begin
        ecl_tmr <= ecl_tmr - 4'h1;
      end
    end
  end

  // Busy throughout formatting, dead time and full buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cannot_accept_hits_output <= 1'b0;
    end else begin
      cannot_accept_hits_output <= (st == S_UNLOAD) || (st == S_DEAD) || full;
    end
  end

  // ==========================================================
  // Trigger outputs, one shaper per group of four channels
  logic frz;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frz <= 1'b0;
    end else if (st == S_IDLE) begin
      frz <= 1'b0;
    end else if (st == S_ACQ && com_rise && tlatch && !ctrl.common_start) begin
      frz <= 1'b1;
    end
  end

  for (genvar g = 0; g < NGRP; g++) begin : g_trig
    logic raw, raw_d, pend, lat;
    logic [7:0] dly, wid;
    assign raw = |hits[g*GRP_W +: GRP_W];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        raw_d <= 1'b0;
        pend <= 1'b0;
        lat <= 1'b0;
        dly <= '0;
        wid <= '0;
        trigger_out[g] <= 1'b0;
      end else begin
        raw_d <= raw;
        if (raw && !raw_d) begin
          pend <= 1'b1;
          dly <= tdel;
        end else if (pend) begin
          if (dly == 8'h0) begin
            pend <= 1'b0;
            wid <= twid;
          end else begin
            dly <= dly - 8'h1;
          end
        end else if (wid != 8'h0) begin
          wid <= wid - 8'h1;
        end
        if (st == S_IDLE) begin
          lat <= 1'b0;
        end else if (st == S_ACQ && raw) begin
          lat <= 1'b1;
        end
        if (!frz) begin
          trigger_out[g] <= ctrl.common_start ? lat : (wid != 8'h0);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/tdc_sva.sv ====
/*
  Port checker for the TDC event digitizer.
  Assumes one pclk domain, presetn low in reset.
*/
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Checker
module tdc_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] ecl_data,
  input wire logic ecl_write_strobe,
  input wire logic ecl_pass,
  input wire logic cannot_accept_hits_output,
  input wire logic addressed_led
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  led_tracks_sel_a: assert property (1'b1 |=> addressed_led == $past(psel))
    else $error("indicator lags select");
  ready_one_cycle_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bad access phase");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  strobe_spacing_a: assert property (ecl_write_strobe |=> !ecl_write_strobe [*8])
    else $error("words too close");
  word_held_a: assert property (!ecl_write_strobe |-> $stable(ecl_data))
    else $error("word moved without strobe");
  pass_on_last_a: assert property ($rose(ecl_pass) |-> ecl_write_strobe)
    else $error("pass without last word");
  one_event_a: assert property (ecl_pass && $past(ecl_pass) |-> !ecl_write_strobe)
    else $error("word after pass");
  busy_holds_a: assert property ($rose(cannot_accept_hits_output) |=> cannot_accept_hits_output [*8])
    else $error("busy too short");
endmodule
bind multihit_tdc_event_digitizer tdc_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .ecl_data(ecl_data),
  .ecl_write_strobe(ecl_write_strobe), .ecl_pass(ecl_pass),
  .cannot_accept_hits_output(cannot_accept_hits_output), .addressed_led(addressed_led));
`default_nettype wire

// ==== verification/ecl_reader.sv ====
/*
  Readout driver model for the ECL event port.
  Assumes the bench raises want to ask for events; lag sets slack.
*/
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Reader
module ecl_reader (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic want,
  input wire logic [2:0] lag,
  input wire logic [15:0] ecl_data,
  input wire logic ecl_write_strobe,
  input wire logic ecl_pass,
  output logic readout_enable_input
);
  logic [2:0] k;
  logic [15:0] q[$];
  // Enable must cycle low between events, so drop it lag cycles after pass
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      readout_enable_input <= 1'b0;
      k <= 3'h0;
    end else begin
      if (ecl_write_strobe) q.push_back(ecl_data);
      if (!want) readout_enable_input <= 1'b0;
      else if (!ecl_pass) begin
        readout_enable_input <= 1'b1;
        k <= 3'h0;
      end else if (k == lag) readout_enable_input <= 1'b0;
      else k <= k + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
/*
  Self-checking bench for the TDC event digitizer.
  Assumes the register map and word layouts of the package.
*/
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Bench
module testbench;
  import tdc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cm = 0, tmo = 0, fclr = 0, want = 0, er;
  logic [7:0] paddr = 0, id;
  logic [31:0] pwdata = 0, prdata, rd, seed = 32'h9b52;
  logic [NCH-1:0] hit = 0;
  logic pready, pslverr, busy, wst, pass;
  logic [NGRP-1:0] trig;
  logic [15:0] ecl_data, t1, t2;
  logic [2:0] lag = 0;
  logic [31:0] w[$];
  wire ren;
  int miscompares = 0, checks_done = 0, cyc = 0, bc, ch;
  multihit_tdc_event_digitizer DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hit_in(hit), .common_hit_input(cm), .timeout_input(tmo),
    .fast_clear_input(fclr), .readout_enable_input(ren), .trigger_out(trig),
    .cannot_accept_hits_output(busy), .ecl_data(ecl_data), .ecl_write_strobe(wst),
    .ecl_pass(pass), .addressed_led());
  ecl_reader rdr (.pclk(pclk), .presetn(presetn), .want(want), .lag(lag), .ecl_data(ecl_data),
    .ecl_write_strobe(wst), .ecl_pass(pass), .readout_enable_input(ren));
  always #5 pclk = ~pclk;
  // Hang guard, well above the full-buffer fill
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      final_report();
    end
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [15:0] hdr(logic both, logic dw);
    return {1'b1, both, dw, 1'b1, 4'h0, id};
  endfunction
  task tick(int n);
    repeat (n) @(posedge pclk);
  endtask
  // Pins pass a 2-stage sync, so pulses last two cycles
  task pulse(int s);
    case (s)
      0: cm <= 1;
      1: tmo <= 1;
      default: fclr <= 1;
    endcase
    tick(2);
    cm <= 0;
    tmo <= 0;
    fclr <= 0;
  endtask
  task apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdev();
    w = {};
    do begin
      apb(0, A_DATA, 0);
      w.push_back(rd);
    end while (rd[16] !== 1'b1 && w.size() < 40);
  endtask
  task idle();
    tick(6);
    while (busy !== 1'b0) tick(1);
  endtask
  task check(logic [63:0] got, logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    seed = 39762;
    tick(10);
    presetn <= 1;
    apb(0, A_CTRL, 0); check(rd, 0);
    apb(0, A_HITS, 0); check(rd, 32'(HITS_RST));
    apb(0, A_FSC, 0); check(rd, 32'(FSC_RST));
    apb(1, 8'h24, 1);
    check(32'(er), 1);
    id = 8'(xs());
    ch = int'(xs() % NCH);
    lag = 3'(xs());
    apb(1, A_IDB, 32'(id));
    apb(1, A_HITS, 1);
    apb(1, A_CTRL, 32'h13);
    // Three edges on one channel, only two may be kept
    pulse(0);
    tick(6);
    repeat (3) begin
      hit[ch] <= 1;
      tick(2);
      hit[ch] <= 0;
      tick(2);
    end
    check(32'(trig), 32'(1) << (ch / 4));
    pulse(1);
    tick(6);
    bc = 0;
    while (busy === 1'b1) begin
      bc++;
      tick(1);
    end
    check(32'(bc > DEAD_BASE_CYC + 2 * DEAD_HIT2_CYC - 10 && bc <= DEAD_BASE_CYC + 2 * DEAD_HIT2_CYC + 10), 1);
    apb(0, A_STAT, 0); check(32'(rd[4:0]), 1);
    // Second event acquires while the first streams out
    pulse(0);
    want <= 1;
    do tick(1); while (pass !== 1'b1);
    tick(10);
    want <= 0;
    check(32'(rdr.q.size()), 5);
    check(32'(rdr.q[0]), 32'(hdr(0, 1)));
    check({rdr.q[1][15:8], rdr.q[3][15:8]}, {1'b0, 5'(ch), 2'b11, 1'b0, 5'(ch), 2'b11});
    t1 = {rdr.q[1][7:0], rdr.q[2][7:0]};
    t2 = {rdr.q[3][7:0], rdr.q[4][7:0]};
    check(32'(t2 - t1), 32'(4 * BINS_PER_CLK));
    pulse(1);
    idle();
    rdev(); check({w.size(), w[0]}, {32'd1, 1'b1, 14'h0, 1'b1, hdr(0, 1)});
    // Empty event with header suppression leaves nothing
    apb(1, A_CTRL, 32'h19);
    pulse(0);
    tick(10);
    pulse(1);
    tick(300);
    apb(0, A_STAT, 0); check(32'(rd[4:0]), 0);
    // Both edges, 1 ns LSB: a two-cycle pulse spans 40 bins, which read as 20 codes, one clock of bins
    apb(1, A_WIN, 32'(1) << WIN_LSB_POS);
    apb(1, A_HITS, 32'(HITS_RST));
    apb(1, A_CTRL, 32'h15);
    pulse(0);
    tick(6);
    hit[ch] <= 1;
    tick(2);
    hit[ch] <= 0;
    tick(6);
    pulse(1);
    idle();
    rdev(); check({w.size(), w[0][15:0]}, {32'd3, hdr(1, 0)});
    check({w[1][15:9], w[2][15:9]}, {1'b0, 5'(ch), 1'b1, 1'b0, 5'(ch), 1'b0});
    check(32'(9'(w[2][8:0] - w[1][8:0])), 32'(BINS_PER_CLK));
    // Test pulser drives every channel, so all common start groups latch
    apb(1, A_TEST, (32'(1) << TEST_GO_BIT) | 32'h0302);
    tick(20);
    check(32'(trig), 32'hff);
    pulse(2);
    tick(4);
    // Fast clear mid-acquisition drops the event and keeps registers
    pulse(0);
    tick(6);
    hit[ch] <= 1;
    tick(3);
    pulse(2);
    hit[ch] <= 0;
    tick(10);
    pulse(1);
    tick(300);
    apb(0, A_STAT, 0); check(32'(rd[4:0]), 0);
    apb(0, A_IDB, 0); check(rd, 32'(id));
    // Common stop: shaped trigger after a delay, stop 16 clocks after the hit
    apb(1, A_WIN, 100);
    apb(1, A_TRIG, 32'h0503);
    apb(1, A_CTRL, 32'h10);
    tick(4);
    hit[ch] <= 1;
    bc = 0;
    repeat (16) begin
      tick(1);
      hit[ch] <= 0;
      bc += int'(trig[ch / 4]);
    end
    check(bc, 5);
    pulse(0);
    idle();
    rdev();
    check({w.size(), w[0][15:0]}, {32'd2, 8'h80, id});
    check(w[1][15:0], {1'b0, 5'(ch), 10'(16 * BINS_PER_CLK - 16'd100)});
    // Fill the event buffer until it refuses
    apb(1, A_CTRL, 32'h11);
    pulse(2); // Close the common stop window left open
    tick(4);
    repeat (31) begin
      pulse(0);
      tick(4);
      pulse(1);
      tick(240);
    end
    apb(0, A_STAT, 0); check({31'h0, busy}, 1);
    check(32'(rd[4:0]), 31);
    rdev();
    tick(5);
    check({31'h0, busy}, 0);
    final_report();
  end
endmodule
`default_nettype wire
